// >>> test/sar_adc_sequencer_test.sv
`timescale 1ns/1ps
module sar_adc_sequencer_test;
    reg clk, rstn, psel, penable, pwrite, idle, trig;
    reg [11:0] paddr;
    reg [31:0] pwdata, seed;
    reg [3:0] lat;
    reg [9:0] pd;
    reg [9:0] ex [0:3];
    wire pready, pslverr, irq, done, start;
    wire [31:0] prdata;
    wire [13:0] pins;
    wire [9:0] cdat;
    wire cken;
    wire [3:0] shs, ch0;
    wire [1:0] csh;
    logic [32:0] q[$];
    integer n_mismatch = 0, checks = 0, cyc = 0, i;

    sarq_top dut_u (
        .core_clk_i(clk), .rstn_i(rstn), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .pready_o(pready), .prdata_o(prdata),
        .pslverr_o(pslverr), .cpu_idle_i(idle), .trig_i(trig),
        .irq_o(irq), .pin_digital_o(pins), .conv_clk_en_o(cken),
        .sh_sample_o(shs), .conv_start_o(start), .conv_sh_o(csh),
        .ch0_input_o(ch0), .conv_done_i(done), .conv_data_i(cdat)
    );
    sarq_core_model core_u (
        .clk_i(clk), .rstn_i(rstn), .start_i(start), .lat_i(lat),
        .data_i(pd), .done_o(done), .data_o(cdat)
    );
    ////////////////////////////////////////
    function logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        xs = x ^ (x << 5);
    endfunction
    function logic [15:0] fmt(input logic [1:0] f, input logic [9:0] d);
        case (f)
            2'h0: fmt = {6'h00, d};
            2'h1: fmt = {{7{~d[9]}}, d[8:0]};
            2'h2: fmt = {d, 6'h00};
            default: fmt = {~d[9], d[8:0], 6'h00};
        endcase
    endfunction
    task chk(input logic [32:0] s, input logic [32:0] e);
        checks++;
        if (s !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %0t seen %h want %h", $time, s, e);
        end
    endtask
    task conclude;
        if (n_mismatch == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rd(input logic [11:0] a, input logic [32:0] e);
        q.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask
    task irq_is(input logic e);
        @(posedge clk);
        chk({32'h0, irq}, {32'h0, e});
    endtask
    // one manual conversion; d is the done state left before it
    task cv(input logic [1:0] f, input logic d);
        seed = xs(seed);
        ex[f] = seed[9:0];
        pd <= seed[9:0];
        lat <= 4'h2 + {1'b0, seed[12:10]};
        apb(1'b1, 12'h000, {16'h0, 6'h20, f, 8'h01});
        rd(12'h000, {17'h0, 6'h20, f, 7'h00, d});
        apb(1'b1, 12'h000, {16'h0, 6'h20, f, 8'h00});
        apb(1'b1, 12'h000, {16'h0, 6'h20, f, 8'h03});
        rd(12'h000, {17'h0, 6'h20, f, 8'h02});
        apb(1'b1, 12'h000, {16'h0, 6'h20, f, 8'h01});
        while (done !== 1'b1) @(posedge clk);
        rd(12'h000, {17'h0, 6'h20, f, 8'h01});
    endtask
    // cycles between two conversion clock enables
    task clk_gap(input logic [7:0] a);
        integer k;
        apb(1'b1, 12'h008, {24'h0, a});
        k = 0;
        do @(posedge clk); while (cken !== 1'b1);
        do begin
            @(posedge clk);
            k++;
        end while (cken !== 1'b1);
        chk(k, {25'h0, a} + 33'h1);
    endtask
    ////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            conclude();
        end
    end
    always @(posedge clk) begin
        if (psel && penable && !pwrite && pready === 1'b1)
            chk({pslverr, prdata}, q.pop_front());
    end
    initial begin
        rstn = 1'b0;
        {psel, penable, pwrite, idle, trig} = 5'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        lat = 4'h2;
        pd = 10'h000;
        seed = 32'd85477;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        rd(12'h000, 33'h0);
        seed = xs(seed);
        apb(1'b1, 12'h010, {16'h0, seed[15:0]});
        rd(12'h010, {17'h0, seed[15:0]});
        chk({19'h0, pins}, {19'h0, seed[13:0]});
        rd(12'h020, {1'b1, 32'h0});
        apb(1'b1, 12'h004, 32'h0000000c);
        apb(1'b1, 12'h01c, 32'h1);
        apb(1'b1, 12'h000, 32'h8000);
        apb(1'b1, 12'h018, 32'h3);
        for (i = 0; i < 4; i++) cv(i[1:0], i != 0);
        irq_is(1'b1);
        apb(1'b1, 12'h01c, 32'h0);
        irq_is(1'b0);
        apb(1'b1, 12'h01c, 32'h1);
        irq_is(1'b1);
        apb(1'b1, 12'h018, 32'h3);
        irq_is(1'b0);
        for (i = 0; i < 4; i++)
            rd({6'h01, i[3:0], 2'h0}, {17'h0, fmt(i[1:0], ex[i])});
        clk_gap(8'h03);
        // module off restarts the scan list
        apb(1'b1, 12'h000, 32'h0);
        apb(1'b1, 12'h00c, 32'h0024);
        apb(1'b1, 12'h004, 32'h0404);
        apb(1'b1, 12'h000, 32'h8000);
        repeat (2) @(posedge clk);
        chk({29'h0, ch0}, 33'h2);
        cv(2'h0, 1'b0);
        chk({29'h0, ch0}, 33'h5);
        cv(2'h0, 1'b1);
        chk({29'h0, ch0}, 33'h2);
        chk({31'h0, csh}, 33'h0);
        // stop in idle holds the sequencer
        idle <= 1'b1;
        apb(1'b1, 12'h000, 32'ha002);
        repeat (2) @(posedge clk);
        chk({29'h0, shs}, 33'h0);
        idle <= 1'b0;
        repeat (2) @(posedge clk);
        chk({29'h0, shs}, 33'h1);
        apb(1'b1, 12'h000, 32'h8000);
        while (done !== 1'b1) @(posedge clk);
        rd(12'h040, {17'h0, fmt(2'h0, ex[0])});
        conclude();
    end
endmodule

// >>> test/sarq_checker_asserts.sv
`timescale 1ns/1ps
module sarq_checker #(
    parameter NUM_INPUTS = 14
) (
    // clock and reset
    input wire core_clk_i,
    input wire rstn_i,
    // apb
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [11:0] paddr_i,
    input wire [31:0] pwdata_i,
    input wire pready_o,
    input wire pslverr_o,
    // system and core
    input wire irq_o,
    input wire [NUM_INPUTS-1:0] pin_digital_o,
    input wire [3:0] sh_sample_o,
    input wire conv_start_o
);
    reg on_r;
    reg [15:0] pcfg_r;
    reg [1:0] msk_r;
    wire wr = psel_i & penable_i & pwrite_i;
    wire unm = paddr_i[11:7] != 5'h00 || paddr_i[6:5] == 2'h1 ||
        (!paddr_i[6] && paddr_i[1:0] != 2'h0);
    // shadow of the written fields the properties lean on
    always @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            on_r <= 1'b0;
            pcfg_r <= 16'h0000;
            msk_r <= 2'h0;
        end else if (wr) begin
            if (paddr_i == 12'h000) on_r <= pwdata_i[15];
            if (paddr_i == 12'h010) pcfg_r <= pwdata_i[15:0];
            if (paddr_i == 12'h01c) msk_r <= pwdata_i[1:0];
        end
    end
    ////////////////////////////////////////
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rstn_i);
    sequence s_start;
        conv_start_o;
    endsequence
    sequence s_quiet;
        !conv_start_o [*2];
    endsequence
    a_ready_high: assert property (pready_o)
        else $error("pready low");
    a_start_gap: assert property (s_start |=> s_quiet)
        else $error("start not a lone pulse");
    a_off_quiet: assert property (!on_r && !$past(on_r) |-> !s_start)
        else $error("start while module off");
    a_pin_map: assert property (pin_digital_o == pcfg_r[NUM_INPUTS-1:0])
        else $error("pin config mismatch");
    a_mask_quiet: assert property (msk_r == 2'h0 |-> !irq_o)
        else $error("irq with all masked");
    a_irq_rise: assert property ($rose(irq_o) |-> msk_r != 2'h0)
        else $error("irq rose while masked");
    a_addr_err: assert property (psel_i && penable_i |-> pslverr_o == unm)
        else $error("wrong slave error");
    a_sample_hold: assert property (sh_sample_o != 4'h0 |-> !s_start)
        else $error("start during sampling");
endmodule
bind sarq_top sarq_checker #(
    .NUM_INPUTS(NUM_INPUTS)
) chk_u (
    .core_clk_i(core_clk_i),
    .rstn_i(rstn_i),
    .psel_i(psel_i),
    .penable_i(penable_i),
    .pwrite_i(pwrite_i),
    .paddr_i(paddr_i),
    .pwdata_i(pwdata_i),
    .pready_o(pready_o),
    .pslverr_o(pslverr_o),
    .irq_o(irq_o),
    .pin_digital_o(pin_digital_o),
    .sh_sample_o(sh_sample_o),
    .conv_start_o(conv_start_o)
);

// >>> test/sarq_core_model.sv
`timescale 1ns/1ps
module sarq_core_model (
    // clock and reset
    input wire clk_i,
    input wire rstn_i,
    // from the sequencer
    input wire start_i,
    // bench settings
    input wire [3:0] lat_i,
    input wire [9:0] data_i,
    // result
    output reg done_o,
    output reg [9:0] data_o
);
    reg [3:0] cnt_r;
    // data valid only in the done cycle, else toggles
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_r <= 4'h0;
            done_o <= 1'b0;
            data_o <= 10'h000;
        end else begin
            cnt_r <= start_i ? lat_i : cnt_r - {3'h0, cnt_r != 4'h0};
            done_o <= cnt_r == 4'h1 && !start_i;
            data_o <= cnt_r == 4'h1 ? data_i : ~data_o;
        end
    end
endmodule

// >>> verilog/sarq_consts.vh
`ifndef SARQ_CONSTS_VH
`define SARQ_CONSTS_VH

// register byte offsets
`define SARQ_ADDR_W 12
`define SARQ_OFF_CTRL1 12'h000
`define SARQ_OFF_CTRL2 12'h004
`define SARQ_OFF_CTRL3 12'h008
`define SARQ_OFF_SCAN 12'h00c
`define SARQ_OFF_PCFG 12'h010
`define SARQ_OFF_INSEL 12'h014
`define SARQ_OFF_ISTAT 12'h018
`define SARQ_OFF_IMASK 12'h01c
`define SARQ_OFF_BUF 12'h040
`define SARQ_BUF_MASK 12'hfc0

// control one fields
`define SARQ_C1_ON 15
`define SARQ_C1_SIDL 13
`define SARQ_C1_FORM_HI 9
`define SARQ_C1_FORM_LO 8
`define SARQ_C1_SSRC_HI 7
`define SARQ_C1_SSRC_LO 5
`define SARQ_C1_SIMULTANEOUS_SAMPLE_SELECT 3
`define SARQ_C1_AUTO_SAMPLE 2
`define SARQ_C1_SAMPLE_ENABLE 1
`define SARQ_C1_DONE 0
`define SARQ_C1_WMASK 16'ha3ec

// control two fields
`define SARQ_C2_SCAN 10
`define SARQ_C2_CHPS_HI 9
`define SARQ_C2_CHPS_LO 8
`define SARQ_C2_SMPI_HI 5
`define SARQ_C2_SMPI_LO 2
`define SARQ_C2_WMASK 16'h073c

// control three fields
`define SARQ_C3_SAMC_HI 12
`define SARQ_C3_SAMC_LO 8
`define SARQ_C3_ADCS_HI 7
`define SARQ_C3_ADCS_LO 0
`define SARQ_C3_WMASK 16'h1fff

// trigger codes
`define SARQ_TRIG_MANUAL 3'h0
`define SARQ_TRIG_AUTO 3'h7

// output format codes
`define SARQ_FMT_UINT 2'h0
`define SARQ_FMT_SINT 2'h1
`define SARQ_FMT_UFRAC 2'h2
`define SARQ_FMT_SFRAC 2'h3

// interrupt status bits
`define SARQ_IRQ_SMPI 0
`define SARQ_IRQ_DONE 1

// reset values
`define SARQ_RST_16 16'h0000

`endif

// >>> verilog/sarq_fmt.v
`timescale 1ns/1ps
`include "sarq_consts.vh"

module sarq_fmt (
    // raw result and format
    input wire [9:0] raw_i,
    input wire [1:0] fmt_i,
    // formatted word
    output reg [15:0] word_o
);
    always @* begin
        case (fmt_i)
            `SARQ_FMT_SFRAC: word_o = {~raw_i[9], raw_i[8:0], 6'h00}; // [R6]
            `SARQ_FMT_UFRAC: word_o = {raw_i, 6'h00}; // [R19]
            `SARQ_FMT_SINT: word_o = {{7{~raw_i[9]}}, raw_i[8:0]}; // [R19]
            default: word_o = {6'h00, raw_i}; // [R19]
        endcase
    end
endmodule

// >>> verilog/sarq_top.v
// Behaviour
// R1: fourteen inputs, each analog or digital by bit
// R2: conversion clock divided from core clock
// R3: two-bit field picks sample-hold channels used
// R4: trigger source and sample time steer sequence
// R5: two-bit field selects result format
// R6: code 11 gives signed left-justified fraction
// R7: conversions run only while module on
// R8: results fill sixteen words in order
// R9: samples-per-interrupt sets conversions per interrupt
// R10: scan walks select list, restarts at interrupt
// R11: done clears at conversion start, sets at end
// R12: software clears done before manual sampling
// R13: sample and done bits hardware settable/clearable
// R14: keeps running in idle unless stop-in-idle
// R15: software clears interrupt flag after setup
// R16: auto-sample sets sample bit, else software
// R17: manual trigger ends sampling by writing zero
// R18: software clears done only, never sets it
// R19: other codes: unsigned frac, signed, unsigned int
//
// Local design decisions: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`include "sarq_consts.vh"

module sarq_top #(
    parameter NUM_INPUTS = 14,
    parameter BUF_WORDS = 16
) (
    // clock and reset
    input wire core_clk_i,
    input wire rstn_i,
    // apb slave
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [11:0] paddr_i,
    input wire [31:0] pwdata_i,
    output wire pready_o,
    output reg [31:0] prdata_o,
    output reg pslverr_o,
    // system
    input wire cpu_idle_i,
    input wire trig_i,
    output wire irq_o,
    // analog core
    output wire [NUM_INPUTS-1:0] pin_digital_o,
    output wire conv_clk_en_o,
    output wire [3:0] sh_sample_o,
    output reg conv_start_o,
    output reg [1:0] conv_sh_o,
    output reg [3:0] ch0_input_o,
    input wire conv_done_i,
    input wire [9:0] conv_data_i
);
    localparam ST_HOLD = 2'h0;
    localparam ST_SAMPLE_ENABLE = 2'h1;
    localparam ST_CONV = 2'h2;

    ////////////////////////////////////////////////////////////////////////
    // registers
    reg [15:0] ctrl1_r;
    reg [15:0] ctrl2_r;
    reg [15:0] ctrl3_r;
    reg [15:0] scan_r;
    reg [15:0] pcfg_r;
    reg [3:0] insel_r;
    reg [1:0] istat_r;
    reg [1:0] imask_r;
    reg [15:0] buf_mem [0:BUF_WORDS-1];
    reg sample_enable_r;
    reg sample_enable_nxt;
    reg done_r;
    reg done_nxt;
    reg [1:0] state_r;
    reg [7:0] div_r;
    reg [4:0] samc_r;
    reg [1:0] conv_k_r;
    reg [1:0] cur_sh_r;
    reg [3:0] bptr_r;
    reg [3:0] scan_pos_r;
    integer i;

    // next set bit after cur, wrapping
    function [3:0] next_scan;
        input [15:0] list;
        input [3:0] cur;
        reg [3:0] idx;
        reg found;
        integer j;
        begin
            next_scan = cur;
            found = 1'b0;
            for (j = 1; j <= 16; j = j + 1) begin
                idx = cur + j[3:0];
                if (!found && list[idx]) begin
                    next_scan = idx;
                    found = 1'b1;
                end
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // field decode
    wire mod_on = ctrl1_r[`SARQ_C1_ON];
    wire [1:0] form = ctrl1_r[`SARQ_C1_FORM_HI:`SARQ_C1_FORM_LO];
    wire [2:0] ssrc = ctrl1_r[`SARQ_C1_SSRC_HI:`SARQ_C1_SSRC_LO];
    wire simultaneous_sample_select = ctrl1_r[`SARQ_C1_SIMULTANEOUS_SAMPLE_SELECT];
    wire auto_sample = ctrl1_r[`SARQ_C1_AUTO_SAMPLE];
    wire scan_en = ctrl2_r[`SARQ_C2_SCAN];
    wire [1:0] chps = ctrl2_r[`SARQ_C2_CHPS_HI:`SARQ_C2_CHPS_LO];
    wire [3:0] smpi = ctrl2_r[`SARQ_C2_SMPI_HI:`SARQ_C2_SMPI_LO];
    wire [4:0] samc = ctrl3_r[`SARQ_C3_SAMC_HI:`SARQ_C3_SAMC_LO];
    wire [7:0] adcs = ctrl3_r[`SARQ_C3_ADCS_HI:`SARQ_C3_ADCS_LO];

    // module runs unless off or halted in idle
    wire run = mod_on && !(cpu_idle_i && ctrl1_r[`SARQ_C1_SIDL]); // [R7] [R14]

    // highest S&H index in use: 0, 1 or 3
    wire [1:0] sh_last = chps[1] ? 2'h3 : {1'b0, chps[0]}; // [R3]
    wire [3:0] sh_used = chps[1] ? 4'hf : (chps[0] ? 4'h3 : 4'h1);
    wire [1:0] conv_last = simultaneous_sample_select ? sh_last : 2'h0;
    wire [1:0] sh_now = simultaneous_sample_select ? conv_k_r : cur_sh_r;

    ////////////////////////////////////////////////////////////////////////
    // apb decode
    wire setup = psel_i && !penable_i;
    wire acc = psel_i && penable_i;
    wire is_buf = (paddr_i & `SARQ_BUF_MASK) == `SARQ_OFF_BUF;
    wire [3:0] buf_idx = paddr_i[5:2];
    wire hit_c1 = paddr_i == `SARQ_OFF_CTRL1;
    wire hit_c2 = paddr_i == `SARQ_OFF_CTRL2;
    wire hit_c3 = paddr_i == `SARQ_OFF_CTRL3;
    wire hit_scan = paddr_i == `SARQ_OFF_SCAN;
    wire hit_pcfg = paddr_i == `SARQ_OFF_PCFG;
    wire hit_insel = paddr_i == `SARQ_OFF_INSEL;
    wire hit_istat = paddr_i == `SARQ_OFF_ISTAT;
    wire hit_imask = paddr_i == `SARQ_OFF_IMASK;
    wire mapped = hit_c1 | hit_c2 | hit_c3 | hit_scan | hit_pcfg |
        hit_insel | hit_istat | hit_imask | is_buf;
    wire wr = acc && pwrite_i && mapped;
    wire wr_c1 = wr && hit_c1;

    assign pready_o = 1'b1;

    always @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            prdata_o <= 32'h00000000;
            pslverr_o <= 1'b0;
        end else if (setup) begin
            pslverr_o <= !mapped;
            prdata_o <= 32'h00000000;
            if (hit_c1)
                prdata_o[15:0] <= {ctrl1_r[15:2], sample_enable_r, done_r};
            if (hit_c2)
                prdata_o[15:0] <= ctrl2_r;
            if (hit_c3)
                prdata_o[15:0] <= ctrl3_r;
            if (hit_scan)
                prdata_o[15:0] <= scan_r;
            if (hit_pcfg)
                prdata_o[15:0] <= pcfg_r;
            if (hit_insel)
                prdata_o[3:0] <= insel_r;
            if (hit_istat)
                prdata_o[1:0] <= istat_r;
            if (hit_imask)
                prdata_o[1:0] <= imask_r;
            if (is_buf)
                prdata_o[15:0] <= buf_mem[buf_idx];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // conversion clock divider: one enable every adcs+1 cycles
    wire conv_ce = div_r == adcs; // [R2]
    assign conv_clk_en_o = conv_ce && mod_on;

    always @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i)
            div_r <= 8'h00;
        else if (!mod_on || conv_ce)
            div_r <= 8'h00;
        else
            div_r <= div_r + 8'h01;
    end

    ////////////////////////////////////////////////////////////////////////
    // sequencer events
    wire [15:0] fmt_word;
    wire hw_trig = (ssrc == `SARQ_TRIG_AUTO) ? (conv_ce && samc_r == 5'h00)
        : (ssrc != `SARQ_TRIG_MANUAL) && trig_i; // [R4]
    wire in_sample_enable = run && state_r == ST_SAMPLE_ENABLE;
    wire start_conv = in_sample_enable && !sample_enable_r; // [R17]
    wire res_ok = run && state_r == ST_CONV && conv_done_i && !conv_start_o;
    wire seq_end = res_ok && conv_k_r == conv_last;
    wire wrap = res_ok && bptr_r == smpi; // [R9]

    sarq_fmt u_fmt (
        .raw_i(conv_data_i),
        .fmt_i(form),
        .word_o(fmt_word)
    ); // [R5]

    // hardware set wins over software write
    always @* begin
        sample_enable_nxt = sample_enable_r;
        if (wr_c1)
            sample_enable_nxt = pwdata_i[`SARQ_C1_SAMPLE_ENABLE]; // [R16] [R17]
        if (in_sample_enable && sample_enable_r && hw_trig)
            sample_enable_nxt = 1'b0; // [R17] [R13]
        if (run && state_r == ST_HOLD && auto_sample)
            sample_enable_nxt = 1'b1; // [R16] [R13]
        if (!mod_on)
            sample_enable_nxt = 1'b0;
    end

    always @* begin
        done_nxt = done_r;
        if (wr_c1 && !pwdata_i[`SARQ_C1_DONE])
            done_nxt = 1'b0; // [R18]
        if (start_conv)
            done_nxt = 1'b0; // [R11]
        if (seq_end)
            done_nxt = 1'b1; // [R11] [R13]
    end

    always @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sample_enable_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            sample_enable_r <= sample_enable_nxt;
            done_r <= done_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sample / convert state machine
    always @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_r <= ST_HOLD;
            samc_r <= 5'h00;
            conv_k_r <= 2'h0;
            cur_sh_r <= 2'h0;
            conv_start_o <= 1'b0;
            bptr_r <= 4'h0;
            scan_pos_r <= 4'h0;
        end else if (!mod_on) begin
            state_r <= ST_HOLD;
            conv_k_r <= 2'h0;
            cur_sh_r <= 2'h0;
            conv_start_o <= 1'b0;
            bptr_r <= 4'h0;
            scan_pos_r <= next_scan(scan_r, 4'hf);
        end else if (run) begin
            conv_start_o <= 1'b0;
            case (state_r)
                ST_HOLD: begin
                    if (sample_enable_r) begin
                        state_r <= ST_SAMPLE_ENABLE;
                        samc_r <= (samc == 5'h00) ? 5'h00 : samc - 5'h01;
                    end
                end
                ST_SAMPLE_ENABLE: begin
                    if (conv_ce && samc_r != 5'h00)
                        samc_r <= samc_r - 5'h01; // [R4]
                    if (!sample_enable_r) begin
                        state_r <= ST_CONV;
                        conv_k_r <= 2'h0;
                        conv_start_o <= 1'b1;
                    end
                end
                ST_CONV: begin
                    if (res_ok) begin
                        bptr_r <= wrap ? 4'h0 : bptr_r + 4'h1; // [R8]
                        if (wrap && scan_en)
                            scan_pos_r <= next_scan(scan_r, 4'hf); // [R10]
                        else if (sh_now == 2'h0 && scan_en)
                            scan_pos_r <= next_scan(scan_r, scan_pos_r);
                        if (seq_end) begin
                            state_r <= ST_HOLD;
                            if (!simultaneous_sample_select)
                                cur_sh_r <= (cur_sh_r == sh_last) ? 2'h0
                                    : cur_sh_r + 2'h1;
                        end else begin
                            conv_k_r <= conv_k_r + 2'h1;
                            conv_start_o <= 1'b1;
                        end
                    end
                end
                default: state_r <= ST_HOLD;
            endcase
        end
    end

    // result buffer: next word in order, not by input number
    always @(posedge core_clk_i) begin
        if (res_ok)
            buf_mem[bptr_r] <= fmt_word; // [R8]
    end

    always @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            conv_sh_o <= 2'h0;
            ch0_input_o <= 4'h0;
        end else begin
            conv_sh_o <= sh_now;
            ch0_input_o <= scan_en ? scan_pos_r : insel_r; // [R10]
        end
    end

    assign sh_sample_o = (run && state_r == ST_SAMPLE_ENABLE) ?
        (simultaneous_sample_select ? sh_used : (4'h1 << cur_sh_r)) : 4'h0; // [R3]
    assign pin_digital_o = pcfg_r[NUM_INPUTS-1:0]; // [R1]

    ////////////////////////////////////////////////////////////////////////
    // control registers and interrupt
    always @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ctrl1_r <= `SARQ_RST_16;
            ctrl2_r <= `SARQ_RST_16;
            ctrl3_r <= `SARQ_RST_16;
            scan_r <= `SARQ_RST_16;
            pcfg_r <= `SARQ_RST_16;
            insel_r <= 4'h0;
            imask_r <= 2'h0;
        end else if (wr) begin
            if (hit_c1)
                ctrl1_r <= pwdata_i[15:0] & `SARQ_C1_WMASK; // [R7]
            if (hit_c2)
                ctrl2_r <= pwdata_i[15:0] & `SARQ_C2_WMASK; // [R9]
            if (hit_c3)
                ctrl3_r <= pwdata_i[15:0] & `SARQ_C3_WMASK; // [R2]
            if (hit_scan)
                scan_r <= pwdata_i[15:0];
            if (hit_pcfg)
                pcfg_r <= pwdata_i[15:0]; // [R1]
            if (hit_insel)
                insel_r <= pwdata_i[3:0];
            if (hit_imask)
                imask_r <= pwdata_i[1:0];
        end
    end

    // sticky status, write one clears, set wins
    always @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            istat_r <= 2'h0;
        end else begin
            for (i = 0; i < 2; i = i + 1) begin
                if (wr && hit_istat && pwdata_i[i])
                    istat_r[i] <= 1'b0;
            end
            if (wrap)
                istat_r[`SARQ_IRQ_SMPI] <= 1'b1; // [R9]
            if (seq_end)
                istat_r[`SARQ_IRQ_DONE] <= 1'b1;
        end
    end

    assign irq_o = |(istat_r & imask_r);

endmodule
